// ---- verilog/shif_pkg.sv ----
// Constants, types and states shared by the sensor host interface
`default_nettype none
package shif_pkg;
    // Bus addressing
    localparam logic [6:0]  ADDR_SELF    = 7'h5A;
    localparam logic [6:0]  ADDR_GCALL   = 7'h00;
    localparam logic [7:0]  GCALL_RESET  = 8'h06;
    // Register address byte fields
    localparam int          PTR_MSB      = 5;
    localparam int          AID_BIT      = 6;
    localparam logic [5:0]  PTR_RESET    = 6'h00;
    // Register locations
    localparam logic [5:0]  REG_COMMAND  = 6'h18;
    localparam logic [5:0]  REG_RESPONSE = 6'h20;
    localparam logic [5:0]  REG_RES_BASE = 6'h22;
    // Command and response codes
    localparam logic [7:0]  CMD_NOP      = 8'h00;
    localparam logic [7:0]  RESP_CLEAR   = 8'h00;
    localparam logic [7:0]  RESP_OVF     = 8'h80;
    localparam logic [15:0] SAT_CODE     = 16'h0FFF;
    // Measurement channels
    localparam logic [1:0]  CH_VIS       = 2'h0;
    localparam logic [1:0]  CH_IR        = 2'h1;

    // One finished conversion from the sequencer
    typedef struct packed {
        logic        valid;
        logic [1:0]  chan;
        logic        ovf;
        logic [15:0] data;
    } shif_meas_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_DATA,
        ST_GCALL,
        ST_ACK,
        ST_READ,
        ST_MACK
    } shif_state_t;
endpackage
`default_nettype wire

// ---- verilog/shif_i2c_target.sv ----
// I2C target, register file, overflow response and ambient interrupt of the sensor
`timescale 1ns/100ps
`default_nettype none
module shif_i2c_target
(
    input  wire logic               i_sys_clk,
    input  wire logic               i_resetn,
    input  wire logic               i_scl_i,
    output logic                    o_scl_o,
    output logic                    o_scl_oe,
    input  wire logic               i_sda_i,
    output logic                    o_sda_o,
    output logic                    o_sda_oe,
    output logic                    o_int_o,
    output logic                    o_int_oe,
    input  wire logic               i_sw_off,
    input  wire shif_pkg::shif_meas_t i_meas,
    input  wire logic               i_auto_mode,
    input  wire logic               i_als_win_mode,
    input  wire logic               i_als_win_ir,
    input  wire logic [15:0]        i_als_thr_low,
    input  wire logic [15:0]        i_als_thr_high,
    input  wire logic               i_int_clear,
    output logic                    o_cmd_wake,
    output logic [7:0]              o_cmd_data,
    output logic                    o_gcall_reset,
    output logic [7:0]              o_response
);

    // ---------------------------------------------------------------
    // Pin synchronisers and bus conditions
    // ---------------------------------------------------------------
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       scl_last_reg;
    logic       sda_last_reg;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;

    // Stage 0 feeds stage 1 only; all logic sees stage 1 and its delayed copy
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_last_reg <= 1'b1;
            sda_last_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], i_scl_i};
            sda_sync_reg <= {sda_sync_reg[0], i_sda_i};
            scl_last_reg <= scl_sync_reg[1];
            sda_last_reg <= sda_sync_reg[1];
        end
    end

    // Edges of the host clock and start/stop seen while clock is high
    assign scl_s     = scl_sync_reg[1];
    assign sda_s     = sda_sync_reg[1];
    assign scl_rise  = scl_s & ~scl_last_reg;
    assign scl_fall  = ~scl_s & scl_last_reg;
    assign bus_start = scl_s & scl_last_reg & sda_last_reg & ~sda_s;
    assign bus_stop  = scl_s & scl_last_reg & ~sda_last_reg & sda_s;

    // ---------------------------------------------------------------
    // Protocol engine
    // ---------------------------------------------------------------
    shif_pkg::shif_state_t st_reg,    st_next;
    shif_pkg::shif_state_t after_reg, after_next;
    logic [2:0]  cnt_reg,  cnt_next;
    logic [7:0]  sh_reg,   sh_next;
    logic [7:0]  tx_reg,   tx_next;
    logic        oe_reg,   oe_next;
    logic        done_reg, done_next;
    logic        ack_reg,  ack_next;
    logic [5:0]  ptr_reg,  ptr_next;
    logic        aid_reg,  aid_next;
    logic        cmdp_reg, cmdp_next;
    logic        gcr_reg,  gcr_next;
    logic [7:0]  cmdd_reg, cmdd_next;
    logic        wr_en;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  byte_in;
    logic [7:0]  rd_data;
    logic [7:0]  tx_shift;
    logic [5:0]  ptr_step;
    logic [7:0]  mem [0:63];
    logic [7:0]  resp_reg, resp_next;

    // Response register is not in the array so overflow can latch independently
    assign rd_data  = (ptr_reg == shif_pkg::REG_RESPONSE) ? resp_reg : mem[ptr_reg];
    assign byte_in  = {sh_reg[6:0], sda_s};
    assign tx_shift = {tx_reg[6:0], 1'b0};
    assign ptr_step = aid_reg ? ptr_reg : ptr_reg + 6'h01;

    // Next state of the engine; no clock stretching, so the host sets the pace
    always_comb
    begin
        st_next    = st_reg;
        after_next = after_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        tx_next    = tx_reg;
        oe_next    = oe_reg;
        done_next  = done_reg;
        ack_next   = ack_reg;
        ptr_next   = ptr_reg;
        aid_next   = aid_reg;
        cmdp_next  = 1'b0;
        gcr_next   = 1'b0;
        cmdd_next  = cmdd_reg;
        wr_en      = 1'b0;
        wr_addr    = ptr_reg;
        wr_data    = byte_in;
        if (i_sw_off)
        begin
            st_next = shif_pkg::ST_IDLE;
            oe_next = 1'b0;
        end
        else if (bus_start)
        begin
            st_next   = shif_pkg::ST_ADDR;
            cnt_next  = 3'h0;
            done_next = 1'b0;
            oe_next   = 1'b0;
        end
        else if (bus_stop)
        begin
            st_next = shif_pkg::ST_IDLE;
            oe_next = 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (st_reg)
                shif_pkg::ST_ADDR, shif_pkg::ST_REG, shif_pkg::ST_DATA, shif_pkg::ST_GCALL:
                begin
                    sh_next  = byte_in;
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == 3'h7)
                    begin
                        done_next = 1'b1;
                        ack_next  = 1'b1;
                        unique case (st_reg)
                            shif_pkg::ST_ADDR:
                            begin
                                // Ten-bit headers never equal either address
                                if (byte_in[7:1] == shif_pkg::ADDR_SELF)
                                    after_next = byte_in[0] ? shif_pkg::ST_READ
                                                            : shif_pkg::ST_REG;
                                else if (byte_in[7:1] == shif_pkg::ADDR_GCALL && !byte_in[0])
                                    after_next = shif_pkg::ST_GCALL;
                                else
                                    ack_next = 1'b0;
                            end
                            shif_pkg::ST_REG:
                            begin
                                // Bit 7 dropped on purpose
                                ptr_next   = byte_in[shif_pkg::PTR_MSB:0];
                                aid_next   = byte_in[shif_pkg::AID_BIT];
                                after_next = shif_pkg::ST_DATA;
                            end
                            shif_pkg::ST_DATA:
                            begin
                                wr_en      = 1'b1;
                                ptr_next   = ptr_step;
                                after_next = shif_pkg::ST_DATA;
                                if (ptr_reg == shif_pkg::REG_COMMAND)
                                begin
                                    // Only this location wakes the sequencer
                                    cmdp_next = 1'b1;
                                    cmdd_next = byte_in;
                                end
                            end
                            default:
                            begin
                                gcr_next   = (byte_in == shif_pkg::GCALL_RESET);
                                after_next = shif_pkg::ST_GCALL;
                            end
                        endcase
                    end
                end
                shif_pkg::ST_READ:
                begin
                    cnt_next  = cnt_reg + 3'h1;
                    done_next = (cnt_reg == 3'h7);
                end
                shif_pkg::ST_MACK:
                    ack_next = ~sda_s;
                default:
                    st_next = st_reg;
            endcase
        end
        else if (scl_fall)
        begin
            unique case (st_reg)
                shif_pkg::ST_ADDR, shif_pkg::ST_REG, shif_pkg::ST_DATA, shif_pkg::ST_GCALL:
                begin
                    if (done_reg)
                    begin
                        done_next = 1'b0;
                        oe_next   = ack_reg;
                        st_next   = ack_reg ? shif_pkg::ST_ACK : shif_pkg::ST_IDLE;
                    end
                end
                shif_pkg::ST_ACK, shif_pkg::ST_MACK:
                begin
                    cnt_next = 3'h0;
                    oe_next  = 1'b0;
                    if ((st_reg == shif_pkg::ST_ACK && after_reg == shif_pkg::ST_READ) ||
                        (st_reg == shif_pkg::ST_MACK && ack_reg))
                    begin
                        // Device drives data bits low through the enable only
                        tx_next  = rd_data;
                        oe_next  = ~rd_data[7];
                        ptr_next = ptr_step;
                        st_next  = shif_pkg::ST_READ;
                    end
                    else if (st_reg == shif_pkg::ST_ACK)
                        st_next = after_reg;
                    else
                        st_next = shif_pkg::ST_IDLE;
                end
                shif_pkg::ST_READ:
                begin
                    if (done_reg)
                    begin
                        done_next = 1'b0;
                        oe_next   = 1'b0;
                        st_next   = shif_pkg::ST_MACK;
                    end
                    else
                    begin
                        tx_next = tx_shift;
                        oe_next = ~tx_shift[7];
                    end
                end
                default:
                    st_next = st_reg;
            endcase
        end
    end

    // Engine registers
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_reg    <= shif_pkg::ST_IDLE;
            after_reg <= shif_pkg::ST_IDLE;
            cnt_reg   <= 3'h0;
            sh_reg    <= 8'h00;
            tx_reg    <= 8'h00;
            oe_reg    <= 1'b0;
            done_reg  <= 1'b0;
            ack_reg   <= 1'b0;
            ptr_reg   <= shif_pkg::PTR_RESET;
            aid_reg   <= 1'b0;
            cmdp_reg  <= 1'b0;
            gcr_reg   <= 1'b0;
            cmdd_reg  <= 8'h00;
        end
        else
        begin
            st_reg    <= st_next;
            after_reg <= after_next;
            cnt_reg   <= cnt_next;
            sh_reg    <= sh_next;
            tx_reg    <= tx_next;
            oe_reg    <= oe_next;
            done_reg  <= done_next;
            ack_reg   <= ack_next;
            ptr_reg   <= ptr_next;
            aid_reg   <= aid_next;
            cmdp_reg  <= cmdp_next;
            gcr_reg   <= gcr_next;
            cmdd_reg  <= cmdd_next;
        end
    end

    // ---------------------------------------------------------------
    // Results, response and ambient interrupt
    // ---------------------------------------------------------------
    logic [15:0] res_val;
    logic [5:0]  res_lo;
    logic [5:0]  res_hi;
    logic        als_chan;
    logic        win_chan;
    logic        int_set;
    logic        int_reg, int_next;

    // A saturated sample reports the code; the next good one replaces it
    assign res_val  = i_meas.ovf ? shif_pkg::SAT_CODE : i_meas.data;
    assign res_lo   = shif_pkg::REG_RES_BASE + {3'h0, i_meas.chan, 1'b0};
    assign res_hi   = res_lo + 6'h01;
    assign als_chan = (i_meas.chan == shif_pkg::CH_VIS) || (i_meas.chan == shif_pkg::CH_IR);
    assign win_chan = i_meas.chan == (i_als_win_ir ? shif_pkg::CH_IR : shif_pkg::CH_VIS);
    assign int_set  = i_meas.valid & i_auto_mode & als_chan &
                      (!i_als_win_mode ||
                       (win_chan && (res_val < i_als_thr_low ||
                                     res_val > i_als_thr_high)));

    // Set wins over every clear, so a saturation in the clearing cycle survives
    always_comb
    begin
        resp_next = resp_reg;
        int_next  = int_reg;
        if (gcr_reg || (cmdp_reg && cmdd_reg == shif_pkg::CMD_NOP))
            resp_next = shif_pkg::RESP_CLEAR;
        if (i_meas.valid && i_meas.ovf)
            resp_next = resp_next | shif_pkg::RESP_OVF;
        if (i_int_clear || gcr_reg)
            int_next = 1'b0;
        if (int_set)
            int_next = 1'b1;
    end

    // Response and interrupt latches
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            resp_reg <= shif_pkg::RESP_CLEAR;
            int_reg  <= 1'b0;
        end
        else
        begin
            resp_reg <= resp_next;
            int_reg  <= int_next;
        end
    end

    // Register array; a result update wins a same-cycle host write to it
    always_ff @(posedge i_sys_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        if (i_meas.valid)
        begin
            mem[res_lo] <= res_val[7:0];
            mem[res_hi] <= res_val[15:8];
        end
    end

    // ---------------------------------------------------------------
    // Pins and status
    // ---------------------------------------------------------------
    // Open drain: level is always low, only enables move
    assign o_scl_o       = 1'b0;
    assign o_scl_oe      = 1'b0;
    assign o_sda_o       = 1'b0;
    assign o_sda_oe      = oe_reg & ~i_sw_off;
    assign o_int_o       = 1'b0;
    assign o_int_oe      = int_reg & ~i_sw_off;
    assign o_cmd_wake    = cmdp_reg;
    assign o_cmd_data    = cmdd_reg;
    assign o_gcall_reset = gcr_reg;
    assign o_response    = resp_reg;

endmodule
`default_nettype wire

// ---- verif/shif_i2c_target_properties.sv ----
// Port-level checker for the sensor host interface
`timescale 1ns/100ps
`default_nettype none
module shif_props
(
    input wire logic                 i_sys_clk,
    input wire logic                 i_resetn,
    input wire logic                 i_sw_off,
    input wire shif_pkg::shif_meas_t i_meas,
    input wire logic                 i_auto_mode,
    input wire logic                 i_als_win_mode,
    input wire logic                 i_als_win_ir,
    input wire logic [15:0]          i_als_thr_low,
    input wire logic [15:0]          i_als_thr_high,
    input wire logic                 o_sda_o,
    input wire logic                 o_sda_oe,
    input wire logic                 o_int_o,
    input wire logic                 o_int_oe,
    input wire logic                 o_cmd_wake,
    input wire logic [7:0]           o_cmd_data,
    input wire logic                 o_gcall_reset,
    input wire logic [7:0]           o_response
);
    // ---
    // Properties
    // ---
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);
    // Window terms; overflowed samples are left out since they compare as 0xFFF
    logic win;
    logic sel;
    logic out;
    assign win = i_auto_mode && i_als_win_mode && i_meas.valid && !i_meas.ovf;
    assign sel = i_meas.chan == (i_als_win_ir ? shif_pkg::CH_IR : shif_pkg::CH_VIS);
    assign out = i_meas.data < i_als_thr_low || i_meas.data > i_als_thr_high;
    // Latch shows next cycle unless the pins are released
    sequence s_raise;
        ##1 (o_int_oe || i_sw_off);
    endsequence
    property p_ovf_set;
        i_meas.valid && i_meas.ovf |=> o_response[7];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");
    property p_ovf_hold;
        $fell(o_response[7]) |-> o_cmd_data == shif_pkg::CMD_NOP
            || o_gcall_reset || $past(o_gcall_reset) || $past(o_gcall_reset, 2);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped");
    property p_every;
        i_auto_mode && !i_als_win_mode && i_meas.valid && i_meas.chan <= shif_pkg::CH_IR
            |-> s_raise;
    endproperty
    a_every: assert property (p_every) else $error("sample did not interrupt");
    property p_win;
        win && sel && out |-> s_raise;
    endproperty
    a_win: assert property (p_win) else $error("window crossing missed");
    property p_inside;
        win && !i_sw_off && !o_int_oe && (!sel || !out) |=> !o_int_oe;
    endproperty
    a_inside: assert property (p_inside) else $error("interrupt inside window");
    property p_cause;
        $rose(o_int_oe) && !$past(i_sw_off) |-> $past(i_meas.valid && i_auto_mode);
    endproperty
    a_cause: assert property (p_cause) else $error("interrupt without sample");
    property p_pins;
        !o_int_o && !o_sda_o;
    endproperty
    a_pins: assert property (p_pins) else $error("pin driven high");
    property p_off;
        i_sw_off [*2] |-> !o_sda_oe && !o_int_oe;
    endproperty
    a_off: assert property (p_off) else $error("pins held while off");
    property p_wake;
        o_cmd_wake |=> !o_cmd_wake [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse too long");
    property p_gcall;
        o_gcall_reset |=> !o_gcall_reset [*8];
    endproperty
    a_gcall: assert property (p_gcall) else $error("reset pulse too long");
endmodule

bind shif_i2c_target shif_props shif_props_inst
(
    .i_sys_clk, .i_resetn, .i_sw_off, .i_meas, .i_auto_mode, .i_als_win_mode, .i_als_win_ir,
    .i_als_thr_low, .i_als_thr_high, .o_sda_o, .o_sda_oe, .o_int_o, .o_int_oe, .o_cmd_wake,
    .o_cmd_data, .o_gcall_reset, .o_response
);
`default_nettype wire

// ---- verif/shif_host_model.sv ----
// Behavioural I2C bus master standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module shif_host_model
(
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output logic      o_scl_low,
    output logic      o_sda_low
);
    // ---
    // Bus phases, every move on the falling clock edge
    // ---
    // Lines released: pull-ups hold them high, clock still between frames
    initial
    begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // Quarter of the 160 ns bus period
    task automatic q();
        repeat (2) @(negedge i_sys_clk);
    endtask
    // Start or repeated start; first quarter lets a target ACK drain
    task automatic start();
        q();
        o_sda_low = 1'b0;
        q();
        o_scl_low = 1'b0;
        q();
        o_sda_low = 1'b1;
        q();
        o_scl_low = 1'b1;
        q();
    endtask
    // Stop: data rises while the clock is high
    task automatic stop();
        o_sda_low = 1'b1;
        q();
        q();
        o_scl_low = 1'b0;
        q();
        o_sda_low = 1'b0;
        q();
    endtask
    // One bit: data set while low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        o_sda_low = ~b;
        q();
        o_scl_low = 1'b0;
        q();
        r = i_sda;
        q();
        o_scl_low = 1'b1;
        q();
    endtask
    // Byte out, most significant bit first, then the target's ACK
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Byte in, then ACK or, on the last byte, NACK
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// ---- verif/shif_i2c_target_tb_top.sv ----
// Self-checking bench for the sensor host interface
`timescale 1ns/100ps
`default_nettype none
module shif_i2c_target_tb_top;
    // ---
    // Bench
    // ---
    localparam logic [7:0]  WA  = {shif_pkg::ADDR_SELF, 1'b0};
    localparam logic [7:0]  RES = {2'h0, shif_pkg::REG_RES_BASE};
    localparam logic [7:0]  CMD = {2'h0, shif_pkg::REG_COMMAND};
    localparam logic [7:0]  KEY = 8'h07; // Arbitrary register location
    localparam logic [1:0]  VIS = shif_pkg::CH_VIS;
    localparam logic [1:0]  IRC = shif_pkg::CH_IR;
    // Window rows: select IR, channel, sample, expected pin level
    localparam logic [19:0] TBL [7] = '{{1'b0, VIS, 16'h0100, 1'b1},
        {1'b0, VIS, 16'h0200, 1'b1}, {1'b0, VIS, 16'h0201, 1'b0}, {1'b0, VIS, 16'h00FF, 1'b0},
        {1'b0, IRC, 16'h0050, 1'b1}, {1'b1, VIS, 16'h0050, 1'b1}, {1'b1, IRC, 16'h0050, 1'b0}};
    logic                 i_sys_clk, i_resetn, i_sw_off, i_auto_mode, i_als_win_mode;
    logic                 i_als_win_ir, i_int_clear, o_cmd_wake, o_gcall_reset;
    logic                 scl_low, sda_low, scl_oe, sda_oe, int_oe, scl_w, sda_w;
    logic [15:0]          i_als_thr_low, i_als_thr_high;
    logic [7:0]           o_cmd_data, o_response;
    shif_pkg::shif_meas_t i_meas;
    int                   n_errors = 0, checks_done = 0, n_wake = 0, n_gcr = 0;
    // Open-drain wires with pull-ups
    assign scl_w = ~(scl_low | scl_oe);
    assign sda_w = ~(sda_low | sda_oe);
    // Clock and pulse counters
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk)
    begin
        n_wake += int'(o_cmd_wake === 1'b1);
        n_gcr += int'(o_gcall_reset === 1'b1);
    end
    shif_i2c_target shif_i2c_target_inst
    (
        .i_sys_clk, .i_resetn, .i_scl_i(scl_w), .o_scl_o(), .o_scl_oe(scl_oe), .i_sda_i(sda_w),
        .o_sda_o(), .o_sda_oe(sda_oe), .o_int_o(), .o_int_oe(int_oe), .i_sw_off, .i_meas,
        .i_auto_mode, .i_als_win_mode, .i_als_win_ir, .i_als_thr_low, .i_als_thr_high,
        .i_int_clear, .o_cmd_wake, .o_cmd_data, .o_gcall_reset, .o_response
    );
    shif_host_model host
    (
        .i_sys_clk, .i_sda(sda_w), .o_scl_low(scl_low), .o_sda_low(sda_low)
    );
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h0, exp}, {7'h0, got});
    endtask
    // Frame of bytes, each ACK judged; stop only when asked
    task automatic send(input logic [7:0] b[$], input logic ok, input logic fin);
        logic a;
        host.start();
        foreach (b[i])
        begin
            host.put(b[i], a);
            chk1("ack", ok, a);
        end
        if (fin)
            host.stop();
    endtask
    // Pointer-only write, repeated start, read run
    task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$]);
        logic [7:0] v;
        send('{WA, ptr}, 1'b1, 1'b0);
        send('{WA | 8'h01}, 1'b1, 1'b0);
        foreach (e[i])
        begin
            host.get(i == e.size() - 1, v);
            chk8("read", e[i], v);
        end
        host.stop();
    endtask
    task automatic meas(input logic [1:0] ch, input logic ovf, input logic [15:0] d);
        i_meas = '{1'b1, ch, ovf, d};
        @(negedge i_sys_clk);
        i_meas.valid = 1'b0;
        repeat (3) @(negedge i_sys_clk);
    endtask
    task automatic clr();
        i_int_clear = 1'b1;
        @(negedge i_sys_clk);
        i_int_clear = 1'b0;
        repeat (2) @(negedge i_sys_clk);
    endtask
    task automatic t_start();
        send('{8'h00, shif_pkg::GCALL_RESET}, 1'b1, 1'b1);
        chk8("reset pulses", 8'h01, 8'(n_gcr));
        send('{WA, KEY, 8'h17}, 1'b1, 1'b1);
    endtask
    task automatic t_burst();
        send('{WA, 8'h85, 8'h11, 8'h22, 8'h33}, 1'b1, 1'b1);
        rd(8'h05, '{8'h11, 8'h22, 8'h33});
        send('{WA, 8'h45, 8'hA5, 8'h5A}, 1'b1, 1'b1);
        rd(8'h05, '{8'h5A, 8'h22});
        rd(8'h45, '{8'h5A, 8'h5A, 8'h5A});
    endtask
    task automatic t_refuse();
        send('{8'hB6}, 1'b0, 1'b1);
        send('{8'hF0}, 1'b0, 1'b1);
        send('{8'h01}, 1'b0, 1'b1);
    endtask
    task automatic t_ovf();
        meas(VIS, 1'b1, 16'h1234);
        chk8("response", shif_pkg::RESP_OVF, o_response);
        rd(RES, '{shif_pkg::SAT_CODE[7:0], shif_pkg::SAT_CODE[15:8]});
        meas(VIS, 1'b0, 16'h0456);
        rd(RES, '{8'h56, 8'h04});
        send('{WA, CMD, 8'h05}, 1'b1, 1'b1);
        chk8("command", 8'h05, o_cmd_data);
        chk8("wakes", 8'h01, 8'(n_wake));
        chk8("response", shif_pkg::RESP_OVF, o_response);
        send('{WA, CMD, shif_pkg::CMD_NOP}, 1'b1, 1'b1);
        chk8("response", shif_pkg::RESP_CLEAR, o_response);
    endtask
    task automatic t_int();
        i_als_thr_low = 16'h0100;
        i_als_thr_high = 16'h0200;
        i_als_win_mode = 1'b1;
        meas(VIS, 1'b0, 16'h0050);
        chk1("int pin", 1'b1, ~int_oe);
        i_auto_mode = 1'b1;
        i_als_win_mode = 1'b0;
        meas(IRC, 1'b0, 16'h0150);
        chk1("int pin", 1'b0, ~int_oe);
        clr();
        i_als_win_mode = 1'b1;
        foreach (TBL[i])
        begin
            i_als_win_ir = TBL[i][19];
            meas(TBL[i][18:17], 1'b0, TBL[i][16:1]);
            chk1("int pin", TBL[i][0], ~int_oe);
            clr();
        end
    endtask
    task automatic t_off();
        i_als_win_mode = 1'b0;
        meas(VIS, 1'b0, 16'h0001);
        i_sw_off = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk1("int pin", 1'b1, ~int_oe);
        chk1("scl enable", 1'b0, scl_oe);
        send('{WA}, 1'b0, 1'b1);
        clr();
        i_sw_off = 1'b0;
        send('{WA}, 1'b1, 1'b1);
    endtask
    task automatic complete_run();
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence: reset, idle bus, then each scenario
    initial
    begin
        i_sys_clk = 1'b0;
        i_resetn = 1'b0;
        i_sw_off = 1'b0;
        i_meas = '0;
        i_auto_mode = 1'b0;
        i_als_win_mode = 1'b0;
        i_als_win_ir = 1'b0;
        i_als_thr_low = '0;
        i_als_thr_high = '0;
        i_int_clear = 1'b0;
        repeat (10) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        t_start();
        t_burst();
        t_refuse();
        t_ovf();
        t_int();
        t_off();
        complete_run();
    end
    // Watchdog, far beyond the five hundred or so bus bits the run needs
    initial
    begin
        #1ms;
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
